// ==== src/bdc_channel.sv ====
// Count and control logic of one bridge DMA channel, with an APB slave.
// Assumes peripheral request lines and a transfer engine on pclk;
// the engine pulses xfer_done for each unit moved on request xfer_go.
`timescale 1ns/1ns
`default_nettype none
module bdc_channel
    import bdc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_timer,
    input wire logic req_uart1,
    input wire logic req_serial,
    input wire logic xfer_done,
    output logic xfer_go,
    output logic [1:0] xfer_size,
    output logic irq_pulse
);
    // ==========================================================
    // Operation overview
    // Register words, by byte address:
    // 0x00 initial count plus source, policy, reload, enable fields.
    // 0x04 current count plus the same upper fields; read only.
    // 0x08 command and setup word.
    // Command word layout:
    // bit 0 start strobe, never stored.
    // bit 1 cancel strobe, never stored.
    // bits 3:2 request enable; zero lets requests through.
    // bits 5:4 unit size: byte, half-word or word.
    // bit 8 busy flag on read, high while a unit moves.
    //
    // Bus timing:
    // Access phase taken while pready is low.
    // pready, prdata and pslverr answer one cycle later.
    // So every access costs exactly one wait state.
    // Writes to the current count word are dropped quietly.
    // Unmapped words raise pslverr and read as zero.
    // A write to an unmapped word changes nothing.
    //
    // Sequencer:
    // Idle: no sequence, or a sequence ended or cancelled.
    // Armed: between units, waiting for the next trigger.
    // Move: one unit handed to the engine, waiting for done.
    // Idle to move loads the current count from the initial one.
    // Armed to move keeps the remaining count.
    // Each done lowers the count by the unit size.
    // A count at or below the step ends the sequence at zero,
    // so a count that does not fit the size cannot wrap.
    // With reload on, the count is refilled and the channel re-arms.
    // With reload off, the enable bit drops and the channel idles.
    // Cancel wins over a trigger or done of the same cycle; an idle trigger still loads the count, a done still updates it and can raise irq_pulse.
    // A late done after cancel lands in idle and is ignored.
    //
    // Triggers:
    // Start strobe, or the selected request with request enable zero.
    // Looked at only in idle and armed, never while a unit moves.
    // A request held high is therefore served once per unit.
    // Requests come from logic on pclk and are not synchronised.
    // A request from a foreign clock needs a synchroniser outside.
    //
    // Interrupts:
    // One-cycle pulse, one cycle after the done that causes it.
    // Policy 01 gives no pulse, the same as polling.
    // A consumer that needs a level must latch the pulse.
    //
    // Software duties:
    // Write the other fields first with enable low, then enable.
    // Keep the count a multiple of the unit size.
    // The enable bit is stored as written; order is not checked.
    //
    // Outputs:
    // All outputs are registers; xfer_size follows the size field.
    // xfer_go is a one-cycle pulse per unit.

    // ==========================================================
    // State
    typedef enum logic [1:0] {BDC_IDLE, BDC_ARMED, BDC_MOVE} bdc_state_t;
    bdc_state_t state, next_state;
    logic [1:0] src_sel, next_src_sel;
    logic [1:0] int_pol, next_int_pol;
    logic auto_reload_enable, next_auto_reload_enable;
    logic chan_en, next_chan_en;
    logic [BDC_CNT_W-1:0] initial_transfer_count, next_initial_transfer_count;
    logic [BDC_CNT_W-1:0] current_transfer_count, next_current_transfer_count;
    logic [1:0] request_enable_setting, next_request_enable_setting;
    logic [1:0] destination_size, next_destination_size;

    // Next values of the outputs
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, next_xfer_go, next_irq_pulse;

    // Decoded strobes and helpers
    logic hw_req;
    logic [BDC_CNT_W-1:0] step;
    logic wr, rd, start_cmd, cancel_cmd, trig, last;

    // ==========================================================
    // Request source select
    always_comb begin
        unique case (bdc_src_t'(src_sel))
            BDC_SRC_TIMER: hw_req = req_timer;
            BDC_SRC_UART1: hw_req = req_uart1;
            BDC_SRC_SERIAL: hw_req = req_serial;
            // No source selected: no request
            BDC_SRC_NONE: hw_req = 1'b0;
        endcase
    end

    // Count step per unit size
    always_comb begin
        unique case (destination_size)
            2'(BDC_SZ_HALF): step = BDC_STEP_HALF;
            2'(BDC_SZ_WORD): step = BDC_STEP_WORD;
            default: step = BDC_STEP_BYTE;
        endcase
    end

    // ==========================================================
    // Bus decode, access phase with one wait state
    assign wr = psel && penable && pwrite && !pready;
    assign rd = psel && penable && !pwrite && !pready;

    // Command strobes from the command word
    assign start_cmd = wr && (paddr == BDC_OFF_CTRL) && pwdata[BDC_CTL_START];
    assign cancel_cmd = wr && (paddr == BDC_OFF_CTRL) && pwdata[BDC_CTL_CANCEL];

    // Trigger and end-of-count detection
    assign trig = start_cmd || (hw_req && (request_enable_setting == BDC_REQEN_ON));
    assign last = (current_transfer_count <= step);

    // Next-state logic for registers, sequencer and bus answer
    always_comb begin
        next_state = state;
        next_src_sel = src_sel;
        next_int_pol = int_pol;
        next_auto_reload_enable = auto_reload_enable;
        next_chan_en = chan_en;
        next_initial_transfer_count = initial_transfer_count;
        next_current_transfer_count = current_transfer_count;
        next_request_enable_setting = request_enable_setting;
        next_destination_size = destination_size;
        next_prdata = prdata;
        next_pready = psel && penable && !pready;
        next_pslverr = 1'b0;
        next_xfer_go = 1'b0;
        next_irq_pulse = 1'b0;

        // Register writes
        if (wr && paddr == BDC_OFF_INIT) begin
            next_src_sel = pwdata[BDC_SRC_HI:BDC_SRC_LO];
            next_int_pol = pwdata[BDC_INT_HI:BDC_INT_LO];
            next_auto_reload_enable = pwdata[BDC_AR_BIT];
            next_chan_en = pwdata[BDC_EN_BIT];
            next_initial_transfer_count = pwdata[BDC_CNT_W-1:0];
        end else if (wr && paddr == BDC_OFF_CTRL) begin
            next_request_enable_setting = pwdata[BDC_CTL_REQEN_HI:BDC_CTL_REQEN_LO];
            next_destination_size = pwdata[BDC_CTL_SIZE_HI:BDC_CTL_SIZE_LO];
        end else if (wr && paddr != BDC_OFF_CURR) begin
            next_pslverr = 1'b1;
        end

        // Register reads; fixed fields show their constant values
        if (rd) begin
            next_prdata = 32'h00000000;
            unique case (paddr)
                BDC_OFF_INIT, BDC_OFF_CURR: begin
                    next_prdata[BDC_SRC_HI:BDC_SRC_LO] = src_sel;
                    next_prdata[BDC_HS_HI:BDC_HS_LO] = BDC_HS_VAL;
                    next_prdata[BDC_UNIT_HI:BDC_UNIT_LO] = BDC_UNIT_VAL;
                    next_prdata[BDC_FLY_HI:BDC_FLY_LO] = BDC_FLY_VAL;
                    next_prdata[BDC_INT_HI:BDC_INT_LO] = int_pol;
                    next_prdata[BDC_AR_BIT] = auto_reload_enable;
                    next_prdata[BDC_EN_BIT] = chan_en;
                    next_prdata[BDC_CNT_W-1:0] = (paddr == BDC_OFF_INIT) ?
                        initial_transfer_count : current_transfer_count;
                end
                BDC_OFF_CTRL: begin
                    next_prdata[BDC_CTL_REQEN_HI:BDC_CTL_REQEN_LO] = request_enable_setting;
                    next_prdata[BDC_CTL_SIZE_HI:BDC_CTL_SIZE_LO] = destination_size;
                    next_prdata[BDC_CTL_BUSY] = (state == BDC_MOVE);
                end
                default: next_pslverr = 1'b1;
            endcase
        end

        // Transfer sequencer
        unique case (state)
            // Idle: a trigger loads the count and starts a unit
            BDC_IDLE: begin
                if (chan_en && trig) begin
                    next_current_transfer_count = initial_transfer_count;
                    next_state = BDC_MOVE;
                    next_xfer_go = 1'b1;
                end
            end
            // Armed: next unit on the next trigger
            BDC_ARMED: begin
                if (!chan_en) begin
                    next_state = BDC_IDLE;
                end else if (trig) begin
                    next_state = BDC_MOVE;
                    next_xfer_go = 1'b1;
                end
            end
            // Move: wait for the engine to finish the unit
            BDC_MOVE: begin
                if (xfer_done) begin
                    next_current_transfer_count = last ? BDC_CNT_RST : current_transfer_count - step;
                    next_irq_pulse = (int_pol == 2'(BDC_INT_EACH)) ||
                        (last && int_pol == 2'(BDC_INT_TERM));
                    // More units, reload, or stop
                    if (!last) begin
                        next_state = BDC_ARMED; // Unit transfer: one unit per trigger
                    end else if (auto_reload_enable) begin
                        next_current_transfer_count = initial_transfer_count;
                        next_state = BDC_ARMED;
                    end else begin
                        next_chan_en = 1'b0;
                        next_state = BDC_IDLE;
                    end
                end
            end
        endcase

        // Cancel overrides state, enable and go
        if (cancel_cmd) begin
            next_chan_en = 1'b0;
            next_state = BDC_IDLE;
            next_xfer_go = 1'b0;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Settings and counts
            state <= BDC_IDLE;
            src_sel <= 2'h0;
            int_pol <= 2'h0;
            auto_reload_enable <= 1'b0;
            chan_en <= 1'b0;
            initial_transfer_count <= BDC_CNT_RST;
            current_transfer_count <= BDC_CNT_RST;
            request_enable_setting <= BDC_REQEN_ON;
            destination_size <= 2'h0;

            // Bus answer
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;

            // Engine side
            xfer_go <= 1'b0;
            xfer_size <= 2'h0;
            irq_pulse <= 1'b0;
        end else begin
            // Settings and counts
            state <= next_state;
            src_sel <= next_src_sel;
            int_pol <= next_int_pol;
            auto_reload_enable <= next_auto_reload_enable;
            chan_en <= next_chan_en;
            initial_transfer_count <= next_initial_transfer_count;
            current_transfer_count <= next_current_transfer_count;
            request_enable_setting <= next_request_enable_setting;
            destination_size <= next_destination_size;

            // Bus answer
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;

            // Engine side
            xfer_go <= next_xfer_go;
            xfer_size <= next_destination_size;
            irq_pulse <= next_irq_pulse;
        end
    end
endmodule
`default_nettype wire

// ==== pkg/bdc_pkg.sv ====
// Constants for the bridge DMA channel count and control block.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package bdc_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] BDC_OFF_INIT = 8'h00;
    localparam logic [7:0] BDC_OFF_CURR = 8'h04;
    localparam logic [7:0] BDC_OFF_CTRL = 8'h08;
    // ==========================================================
    // Field positions
    localparam int BDC_SRC_HI = 31;
    localparam int BDC_SRC_LO = 30;
    localparam int BDC_HS_HI = 29;
    localparam int BDC_HS_LO = 28;
    localparam int BDC_UNIT_HI = 27;
    localparam int BDC_UNIT_LO = 26;
    localparam int BDC_FLY_HI = 25;
    localparam int BDC_FLY_LO = 24;
    localparam int BDC_INT_HI = 23;
    localparam int BDC_INT_LO = 22;
    localparam int BDC_AR_BIT = 21;
    localparam int BDC_EN_BIT = 20;
    localparam int BDC_CNT_W = 20;
    // ==========================================================
    // Fixed field values and reset values
    localparam logic [1:0] BDC_HS_VAL = 2'h0;
    localparam logic [1:0] BDC_UNIT_VAL = 2'h1;
    localparam logic [1:0] BDC_FLY_VAL = 2'h0;
    localparam logic [BDC_CNT_W-1:0] BDC_CNT_RST = 20'h00000;
    localparam logic [BDC_CNT_W-1:0] BDC_STEP_BYTE = 20'h00001;
    localparam logic [BDC_CNT_W-1:0] BDC_STEP_HALF = 20'h00002;
    localparam logic [BDC_CNT_W-1:0] BDC_STEP_WORD = 20'h00004;
    // Control register bits
    localparam int BDC_CTL_START = 0;
    localparam int BDC_CTL_CANCEL = 1;
    localparam int BDC_CTL_REQEN_LO = 2;
    localparam int BDC_CTL_REQEN_HI = 3;
    localparam int BDC_CTL_SIZE_LO = 4;
    localparam int BDC_CTL_SIZE_HI = 5;
    localparam int BDC_CTL_BUSY = 8;
    // ==========================================================
    // Encodings
    typedef enum logic [1:0] {
        BDC_SRC_NONE = 2'h0,
        BDC_SRC_TIMER = 2'h1,
        BDC_SRC_UART1 = 2'h2,
        BDC_SRC_SERIAL = 2'h3
    } bdc_src_t;
    typedef enum logic [1:0] {
        BDC_INT_POLL = 2'h0,
        BDC_INT_UNUSED = 2'h1,
        BDC_INT_EACH = 2'h2,
        BDC_INT_TERM = 2'h3
    } bdc_int_t;
    typedef enum logic [1:0] {
        BDC_SZ_BYTE = 2'h0,
        BDC_SZ_HALF = 2'h1,
        BDC_SZ_WORD = 2'h2
    } bdc_size_t;
    localparam logic [1:0] BDC_REQEN_ON = 2'h0;
endpackage

// ==== tb/bdc_channel_props.sv ====
// Port checker for the channel block.
// Assumes binding to bdc_channel.
`timescale 1ns/1ns
`default_nettype none
module bdc_channel_props
    import bdc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic req_timer,
    input wire logic req_uart1,
    input wire logic req_serial,
    input wire logic xfer_done,
    input wire logic xfer_go,
    input wire logic irq_pulse
);
    // ==========
    // Timing relations
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    unit_pulse_a: assert property (xfer_go |=> !xfer_go)
        else $error("go too long");
    go_cause_a: assert property (xfer_go |-> $past(req_timer || req_uart1 || req_serial ||
        psel && penable && !pready && pwrite && paddr == BDC_OFF_CTRL && pwdata[BDC_CTL_START]))
        else $error("go without trigger");
    irq_cause_a: assert property (irq_pulse |-> $past(xfer_done))
        else $error("irq without done");
    irq_single_a: assert property (irq_pulse |=> !irq_pulse)
        else $error("irq too long");
    ready_once_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("ready timing");
    err_zero_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
        else $error("unmapped data");
    rst_quiet_a: assert property ($rose(presetn) |-> !xfer_go && !irq_pulse && !pready)
        else $error("busy after reset");
    fixed_read_a: assert property (pready && !pwrite && !pslverr && paddr != BDC_OFF_CTRL
        |-> prdata[29:24] == 6'h04) else $error("fixed fields");
    go_seen_c: cover property (xfer_go);
    irq_seen_c: cover property (irq_pulse);
    err_seen_c: cover property (pslverr);
endmodule
bind bdc_channel bdc_channel_props i_props(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_timer(req_timer), .req_uart1(req_uart1),
    .req_serial(req_serial), .xfer_done(xfer_done), .xfer_go(xfer_go), .irq_pulse(irq_pulse));
`default_nettype wire

// ==== tb/bdc_engine_model.sv ====
// Engine stand-in: one done pulse per go.
// Assumes dly is changed only between units.
`timescale 1ns/1ns
`default_nettype none
module bdc_engine_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic xfer_go,
    input wire logic [3:0] dly,
    output logic xfer_done
);
    logic busy;
    logic [3:0] cnt;
    // Count down the delay, then pulse done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            xfer_done <= 1'b0;
        end else begin
            xfer_done <= busy && cnt == 4'h0;
            if (xfer_go) begin
                busy <= 1'b1;
                cnt <= dly;
            end else if (busy) begin
                busy <= cnt != 4'h0;
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/bridge_dma_channel_count_control_tb.sv ====
// Bench for the channel count and control block.
// Assumes the engine model closes every unit.
`timescale 1ns/1ns
`default_nettype none
module bridge_dma_channel_count_control_tb;
    import bdc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, xfer_go, xfer_done, irq_pulse, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0] xfer_size;
    logic [2:0] reqs = 3'h0;
    logic [3:0] dly = 4'h0;
    int error_cnt = 0, cmp_count = 0, go_cnt = 0, irq_cnt = 0, done_cnt = 0;
    // ==========
    // Clock, event counters, design
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        go_cnt <= go_cnt + int'(xfer_go === 1'b1);
        irq_cnt <= irq_cnt + int'(irq_pulse === 1'b1);
        done_cnt <= done_cnt + int'(xfer_done === 1'b1);
    end
    bdc_channel i_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req_timer(reqs[0]), .req_uart1(reqs[1]), .req_serial(reqs[2]), .xfer_done(xfer_done),
        .xfer_go(xfer_go), .xfer_size(xfer_size), .irq_pulse(irq_pulse));
    bdc_engine_model i_eng(.pclk(pclk), .presetn(presetn), .xfer_go(xfer_go), .dly(dly),
        .xfer_done(xfer_done));
    // ==========
    // Tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Hold the request until pready is seen high at a rising edge
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic trig(input logic [1:0] src, input logic [1:0] sz);
        logic [2:0] oh;
        int g;
        oh = 3'((4'h1 << src) >> 1);
        g = go_cnt;
        @(posedge pclk);
        reqs <= ~oh;
        wait_n(3);
        chk("go_src", g, go_cnt);
        reqs <= oh;
        if (src == 2'h0) apb(1'b1, BDC_OFF_CTRL, {26'h0, sz, 4'h1});
        while (go_cnt == g) @(negedge pclk);
        @(posedge pclk);
        reqs <= 3'h0;
    endtask
    task automatic run(input logic [1:0] src, sz, pol, input logic ar, input logic [19:0] cnt, input int n);
        logic [31:0] init;
        int g, d, q;
        init = {src, 4'h1, 2'h0, pol, ar, 1'b0, cnt};
        q = irq_cnt;
        apb(1'b1, BDC_OFF_INIT, init);
        g = go_cnt;
        apb(1'b1, BDC_OFF_CTRL, {26'h0, sz, 4'h1});
        chk("size", 32'(sz), 32'(xfer_size));
        wait_n(4);
        chk("go_off", g, go_cnt);
        apb(1'b1, BDC_OFF_INIT, init | 32'h00100000);
        for (int i = 1; i <= n; i++) begin
            d = done_cnt;
            trig(src, sz);
            while (done_cnt == d) @(negedge pclk);
            wait_n(2);
            apb(1'b0, BDC_OFF_CURR, 32'h0);
            chk("count", (ar && i == n) ? cnt : cnt - 20'(i << sz), rd[19:0]);
        end
        chk("irq", pol == BDC_INT_EACH ? n : pol == BDC_INT_TERM, irq_cnt - q);
        apb(1'b0, BDC_OFF_INIT, 32'h0);
        chk("init", init | {11'h0, ar, 20'h0}, rd);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ==========
    // Main sequence
    initial begin
        int g;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, BDC_OFF_INIT, 32'h0);
        chk("init_rst", 32'h04000000, rd);
        apb(1'b0, BDC_OFF_CURR, 32'h0);
        chk("curr_rst", 32'h04000000, rd);
        apb(1'b1, BDC_OFF_INIT, 32'hFFEFFFFF);
        apb(1'b0, BDC_OFF_INIT, 32'h0);
        chk("fixed", 32'hC4EFFFFF, rd);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped", 32'h1, 32'(err));
        run(2'h0, BDC_SZ_BYTE, BDC_INT_EACH, 1'b0, 20'h00003, 3);
        run(2'h1, BDC_SZ_HALF, BDC_INT_TERM, 1'b0, 20'h00004, 2);
        dly <= 4'h5;
        run(2'h2, BDC_SZ_WORD, BDC_INT_POLL, 1'b0, 20'h00008, 2);
        run(2'h3, BDC_SZ_WORD, BDC_INT_EACH, 1'b1, 20'h00004, 1);
        g = go_cnt;
        wait_n(10);
        chk("go_armed", g, go_cnt);
        dly <= 4'h8;
        trig(2'h3, BDC_SZ_WORD);
        apb(1'b1, BDC_OFF_CTRL, 32'h00000022);
        apb(1'b0, BDC_OFF_INIT, 32'h0);
        chk("en_cancel", 32'h0, rd & 32'h00100000);
        print_verdict();
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
